// >>> design/rph_pkg.sv
// shared constants and types of the radio packet handler
package rph_pkg;

  localparam int unsigned FIFO_DEPTH = 64;

  localparam logic [7:0] OFF_CTRL    = 8'h00;
  localparam logic [7:0] OFF_FLEN    = 8'h04;
  localparam logic [7:0] OFF_AUX     = 8'h08;
  localparam logic [7:0] OFF_IRQ_ST  = 8'h0C;
  localparam logic [7:0] OFF_IRQ_MSK = 8'h10;
  localparam logic [7:0] OFF_FIFO    = 8'h14;
  localparam logic [7:0] OFF_LEVEL   = 8'h18;

  localparam int unsigned WHITEN_BIT     = 6;
  localparam int unsigned FMT_HI         = 5;
  localparam int unsigned FMT_LO         = 4;
  localparam int unsigned LEN_HI         = 1;
  localparam int unsigned LEN_LO         = 0;
  localparam int unsigned AUX_APPEND_BIT = 0;
  localparam int unsigned AUX_GO_BIT     = 1;

  localparam logic [1:0] FMT_NORMAL = 2'h0;
  localparam logic [1:0] LEN_FIXED  = 2'h0;
  localparam logic [1:0] LEN_VAR    = 2'h1;

  localparam logic [7:0] CTRL_RST       = 8'h01;
  localparam logic [7:0] FLEN_RST       = 8'h3E;
  localparam logic       AUX_APPEND_RST = 1'b1;

  localparam int unsigned IRQ_W    = 3;
  localparam int unsigned IRQ_SYNC = 0;
  localparam int unsigned IRQ_EOP  = 1;
  localparam int unsigned IRQ_DROP = 2;

  localparam logic [8:0]  PRE_LAST      = 9'h003;
  localparam logic [7:0]  PREAMBLE_BYTE = 8'h55;
  localparam logic [15:0] SYNC_WORD     = 16'h3C5A;
  localparam logic [8:0]  PN9_SEED      = 9'h1FF;

  typedef struct packed {
    logic [7:0] signal_strength_value;
    logic       crc_ok;
    logic [6:0] link_quality_value;
  } rph_rx_meta_t;

  typedef enum logic [4:0] {
    R_HUNT = 5'h01,
    R_LEN  = 5'h02,
    R_DATA = 5'h04,
    R_ST1  = 5'h08,
    R_ST2  = 5'h10
  } rph_rx_state_t;

  typedef enum logic [3:0] {
    T_IDLE = 4'h1,
    T_PRE  = 4'h2,
    T_SYNC = 4'h4,
    T_DATA = 4'h8
  } rph_tx_state_t;

endpackage : rph_pkg

// >>> design/rph_whiten.sv
// pn9 whitening sequence, one byte per step
`timescale 1ns/1ps
module rph_whiten
  import rph_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       restart,
  input  wire logic       step,
  input  wire logic [7:0] data_in,
  output wire logic [7:0] data_out
);

  logic [8:0] lfsr_q;

  function automatic logic [8:0] pn9_adv8(input logic [8:0] s);
    logic [8:0] v;
    v = s;
    for (int i = 0; i < 8; i++) begin
      v = {v[5] ^ v[0], v[8:1]};
    end
    return v;
  endfunction : pn9_adv8

  assign data_out = data_in ^ lfsr_q[7:0];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lfsr_q <= PN9_SEED;
    end else if (restart) begin
      lfsr_q <= PN9_SEED;
    end else if (step) begin
      lfsr_q <= pn9_adv8(lfsr_q);
    end
  end

endmodule : rph_whiten

// >>> design/rph_fifo.sv
// byte fifo whose writes become visible only on commit
`timescale 1ns/1ps
module rph_fifo #(
  parameter int unsigned DEPTH = 64
) (
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     wr_en,
  input  wire logic [7:0]               wr_data,
  input  wire logic                     commit,
  input  wire logic                     rollback,
  input  wire logic                     rd_en,
  output wire logic [7:0]               rd_data,
  output wire logic [$clog2(DEPTH):0]   level,
  output wire logic                     full,
  output wire logic                     empty
);

  localparam int unsigned AW = $clog2(DEPTH);

  if ((DEPTH & (DEPTH - 1)) != 0 || DEPTH < 4) begin : g_bad
    $error("fifo depth must be a power of two");
  end

  logic [7:0]  mem [DEPTH];
  logic [AW:0] wr_q;
  logic [AW:0] cmt_q;
  logic [AW:0] rd_q;

  // rollback returns to the last commit, so a dropped packet never shows
  wire          do_wr   = wr_en & ~full;
  wire          do_rd   = rd_en & ~empty;
  wire [AW:0]   wr_next = do_wr ? wr_q + 1'b1 : wr_q;
  wire [AW:0]   tent    = wr_q - rd_q;

  assign level   = cmt_q - rd_q;
  assign full    = tent == (AW+1)'(DEPTH);
  assign empty   = level == '0;
  assign rd_data = mem[rd_q[AW-1:0]];

  always_ff @(posedge pclk) begin
    if (do_wr) begin
      mem[wr_q[AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_q  <= '0;
      cmt_q <= '0;
      rd_q  <= '0;
    end else begin
      wr_q  <= rollback ? cmt_q : wr_next;
      cmt_q <= commit ? wr_next : cmt_q;
      rd_q  <= do_rd ? rd_q + 1'b1 : rd_q;
    end
  end

endmodule : rph_fifo

// >>> design/rph_top.sv
// radio packet handler: apb registers, fifos, rx and tx packet engines
//////////////////////////////////////////////////////////////////////
// Contract
// [RULE_01] packet bytes pass through 64-byte fifos
// [RULE_02] insert preamble, sync; detect sync; whiten; filter
// [RULE_03] fifo holds length byte then data
// [RULE_04] append two status bytes per good packet
// [RULE_05] first status byte is signal strength
// [RULE_06] second byte: checksum flag, link quality
// [RULE_07] firmware keeps packets within 62 or 61
// [RULE_08] sync event at start, end event after
// [RULE_09] format field 00 selects fifo operation
// [RULE_10] length mode 01 takes first byte as length
// [RULE_11] fixed mode drops packets of other length
// [RULE_12] processor reads fifo after end event
// [RULE_13] firmware reads status bytes after data
// [RULE_14] length mode 00 uses fixed length value
// [RULE_15] dropped packet raises no end event
//
// Our own choices: the register addresses and the APB slave port.
`timescale 1ns/1ps
module rph_top
  import rph_pkg::*;
#(
  parameter int unsigned DEPTH = FIFO_DEPTH
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output wire logic [31:0]  prdata,
  output wire logic         pready,
  output wire logic         pslverr,
  output wire logic         irq,
  input  wire logic         rx_valid,
  input  wire logic [7:0]   rx_byte,
  input  wire logic         rx_end,
  input  wire rph_rx_meta_t rx_meta,
  input  wire logic         tx_ready,
  output wire logic         tx_valid,
  output wire logic [7:0]   tx_byte
);

  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH > 64 || DEPTH < 4) begin : g_bad
    $error("depth must lie between 4 and 64");
  end

  function automatic logic [31:0] ext8(input logic [7:0] v);
    return {24'h000000, v};
  endfunction : ext8

  //////////////////////////////////////////////////////////////////////
  // registers and bus answer
  logic [7:0]       ctrl_q;
  logic [7:0]       flen_q;
  logic             append_q;
  logic [IRQ_W-1:0] irq_st_q;
  logic [IRQ_W-1:0] mask_q;
  logic [31:0]      prdata_q;
  logic             pready_q;
  logic             pslverr_q;
  logic             irq_q;
  logic             pop_ok_q;

  // rx and tx engine state
  rph_rx_state_t    rs_q;
  rph_rx_state_t    rs_d;
  rph_tx_state_t    ts_q;
  rph_tx_state_t    ts_d;
  logic [8:0]       rcnt_q;
  logic [8:0]       rcnt_d;
  logic [7:0]       rlen_q;
  logic [7:0]       rlen_d;
  logic [7:0]       sr_q;
  rph_rx_meta_t     meta_q;
  logic [8:0]       tcnt_q;
  logic [8:0]       tcnt_d;
  logic [7:0]       tlen_q;
  logic [7:0]       tlen_d;
  logic             tx_valid_q;
  logic             tv_d;
  logic [7:0]       tx_byte_q;
  logic [7:0]       tb_d;

  logic             rx_push;
  logic [7:0]       rx_wd;
  logic             rx_commit;
  logic             rx_drop;
  logic             rx_sync;
  logic             rx_eop;
  logic             tx_pop;
  logic             tx_sync;
  logic             tx_eop;

  wire [7:0]  rx_head;
  wire [AW:0] rx_lvl;
  wire        rx_full;
  wire        rx_empty;
  wire [7:0]  tx_head;
  wire [AW:0] tx_lvl;
  wire        tx_empty;
  wire [7:0]  rxw_out;
  wire [7:0]  txw_out;

  //////////////////////////////////////////////////////////////////////
  // apb decode
  wire setup    = psel & ~penable;
  wire access   = psel & penable & pready_q;
  wire wr_acc   = access & pwrite;
  wire hit_ctrl = paddr == OFF_CTRL;
  wire hit_flen = paddr == OFF_FLEN;
  wire hit_aux  = paddr == OFF_AUX;
  wire hit_ist  = paddr == OFF_IRQ_ST;
  wire hit_msk  = paddr == OFF_IRQ_MSK;
  wire hit_fifo = paddr == OFF_FIFO;
  wire hit_lvl  = paddr == OFF_LEVEL;
  wire addr_ok  = hit_ctrl | hit_flen | hit_aux | hit_ist | hit_msk
                | hit_fifo | hit_lvl;
  // pop only what the setup cycle returned; a commit between setup and
  // access would otherwise pop a byte that was read back as zero
  wire rx_pop   = access & ~pwrite & hit_fifo & pop_ok_q;
  wire tx_wr    = wr_acc & hit_fifo;

  wire [7:0] lvl_rx = {{(7 - AW){1'b0}}, rx_lvl};
  wire [7:0] lvl_tx = {{(7 - AW){1'b0}}, tx_lvl};
  wire [31:0] lvl_word = {8'h00, lvl_rx, lvl_tx, 6'h00,
                          ts_q != T_IDLE, rs_q != R_HUNT};
  wire [31:0] rd_mux =
      hit_ctrl ? ext8(ctrl_q)
    : hit_flen ? ext8(flen_q)
    : hit_aux  ? ext8({7'h00, append_q})
    : hit_ist  ? {{(32 - IRQ_W){1'b0}}, irq_st_q}
    : hit_msk  ? {{(32 - IRQ_W){1'b0}}, mask_q}
    : hit_fifo ? (rx_empty ? 32'h00000000 : ext8(rx_head))
    : hit_lvl  ? lvl_word
    : 32'h00000000;

  // mode fields
  wire fmt_normal = ctrl_q[FMT_HI:FMT_LO] == FMT_NORMAL; // [RULE_09]
  wire var_mode   = ctrl_q[LEN_HI:LEN_LO] == LEN_VAR;    // [RULE_10]
  wire whiten_en  = ctrl_q[WHITEN_BIT];                   // [RULE_02]
  wire [8:0] flen9 = {1'b0, flen_q};                      // [RULE_14]
  wire tx_go = wr_acc & hit_aux & pwdata[AUX_GO_BIT]
             & (ts_q == T_IDLE) & fmt_normal;

  // events: set wins over a write-one clear in the same cycle
  wire [IRQ_W-1:0] ev     = {rx_drop, rx_eop | tx_eop, rx_sync | tx_sync};
  wire [IRQ_W-1:0] clr    = (wr_acc & hit_ist) ? pwdata[IRQ_W-1:0] : '0;
  wire [IRQ_W-1:0] irq_st_d = (irq_st_q & ~clr) | ev; // [RULE_08]

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q    <= CTRL_RST;
      flen_q    <= FLEN_RST;
      append_q  <= AUX_APPEND_RST;
      mask_q    <= '0;
      irq_st_q  <= '0;
      irq_q     <= 1'b0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h00000000;
      pop_ok_q  <= 1'b0;
    end else begin
      pop_ok_q  <= setup & ~pwrite & hit_fifo & ~rx_empty;
      if (wr_acc & hit_ctrl) ctrl_q <= pwdata[7:0];
      if (wr_acc & hit_flen) flen_q <= pwdata[7:0];
      if (wr_acc & hit_aux) append_q <= pwdata[AUX_APPEND_BIT];
      if (wr_acc & hit_msk) mask_q <= pwdata[IRQ_W-1:0];
      irq_st_q  <= irq_st_d;
      irq_q     <= |(irq_st_q & mask_q);
      pready_q  <= setup;
      pslverr_q <= setup & ~addr_ok;
      prdata_q  <= (setup & ~pwrite) ? rd_mux : 32'h00000000;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // receive engine
  wire [7:0] rx_d     = whiten_en ? rxw_out : rx_byte;
  wire       sync_hit = {sr_q, rx_byte} == SYNC_WORD; // [RULE_02]
  wire       in_body  = (rs_q == R_LEN) | (rs_q == R_DATA);

  always_comb begin
    rs_d      = rs_q;
    rcnt_d    = rcnt_q;
    rlen_d    = rlen_q;
    rx_push   = 1'b0;
    rx_wd     = rx_d;
    rx_commit = 1'b0;
    rx_drop   = 1'b0;
    rx_sync   = 1'b0;
    rx_eop    = 1'b0;
    case (rs_q)
      R_HUNT: begin
        if (fmt_normal && rx_valid && sync_hit) begin
          rx_sync = 1'b1; // [RULE_08]
          rcnt_d  = 9'h000;
          rs_d    = var_mode ? R_LEN : R_DATA;
        end
      end
      R_LEN: begin
        if (rx_end) begin
          rx_drop = 1'b1;
        end else if (rx_valid) begin
          rx_push = 1'b1; // [RULE_03]
          rlen_d  = rx_d; // [RULE_10]
          rs_d    = (rx_d == 8'h00) ? R_ST1 : R_DATA;
        end
      end
      R_DATA: begin
        if (rx_valid) begin
          rx_push = 1'b1;
          rcnt_d  = rcnt_q + 9'h001;
        end
        if (var_mode && rx_valid && rcnt_d == {1'b0, rlen_q}) begin
          rs_d = R_ST1;
        end else if (rx_end) begin
          if (var_mode || rcnt_d != flen9) rx_drop = 1'b1; // [RULE_11]
          else rs_d = R_ST1; // [RULE_14]
        end else if (!var_mode && rcnt_d > flen9) begin
          rx_drop = 1'b1; // [RULE_11]
        end
      end
      R_ST1: begin
        if (append_q) begin
          rx_push = 1'b1; // [RULE_04]
          rx_wd   = meta_q.signal_strength_value; // [RULE_05]
          rs_d    = R_ST2;
        end else begin
          rx_commit = 1'b1;
          rx_eop    = 1'b1;
          rs_d      = R_HUNT;
        end
      end
      R_ST2: begin
        rx_push   = 1'b1;
        rx_wd     = {meta_q.crc_ok, meta_q.link_quality_value}; // [RULE_06]
        rx_commit = 1'b1;
        rx_eop    = 1'b1; // [RULE_08]
        rs_d      = R_HUNT;
      end
      default: begin
        rs_d = R_HUNT;
      end
    endcase
    // overflow or a format change mid-packet also discards it
    if ((rx_push && rx_full) || (!fmt_normal && rs_q != R_HUNT)) begin
      rx_drop = 1'b1;
    end
    if (rx_drop) begin
      rs_d      = R_HUNT;
      rx_push   = 1'b0;
      rx_commit = 1'b0;
      rx_eop    = 1'b0; // [RULE_15]
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rs_q   <= R_HUNT;
      rcnt_q <= 9'h000;
      rlen_q <= 8'h00;
      sr_q   <= 8'h00;
      meta_q <= '0;
    end else begin
      rs_q   <= rs_d;
      rcnt_q <= rcnt_d;
      rlen_q <= rlen_d;
      if (rx_valid) sr_q <= rx_byte;
      if (in_body && (rx_valid || rx_end)) meta_q <= rx_meta;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // transmit engine
  wire       ld       = ~tx_valid_q | tx_ready;
  wire [8:0] tx_total = var_mode ? {1'b0, tlen_q} + 9'h001 : flen9;

  always_comb begin
    ts_d    = ts_q;
    tcnt_d  = tcnt_q;
    tlen_d  = tlen_q;
    tv_d    = tx_valid_q & ~tx_ready;
    tb_d    = tx_byte_q;
    tx_pop  = 1'b0;
    tx_sync = 1'b0;
    tx_eop  = 1'b0;
    case (ts_q)
      T_IDLE: begin
        if (tx_go) begin
          ts_d   = T_PRE;
          tcnt_d = 9'h000;
        end
      end
      T_PRE: begin
        if (ld) begin
          tv_d   = 1'b1;
          tb_d   = PREAMBLE_BYTE; // [RULE_02]
          tcnt_d = tcnt_q + 9'h001;
          if (tcnt_q == PRE_LAST) begin
            ts_d   = T_SYNC;
            tcnt_d = 9'h000;
          end
        end
      end
      T_SYNC: begin
        if (ld) begin
          tv_d    = 1'b1;
          tb_d    = tcnt_q[0] ? SYNC_WORD[7:0] : SYNC_WORD[15:8];
          tx_sync = tcnt_q == 9'h000; // [RULE_08]
          tcnt_d  = tcnt_q + 9'h001;
          if (tcnt_q[0]) begin
            ts_d   = T_DATA;
            tcnt_d = 9'h000;
          end
        end
      end
      T_DATA: begin
        if (ld) begin
          if (tcnt_q == tx_total) begin
            ts_d   = T_IDLE;
            tx_eop = 1'b1; // [RULE_08]
          end else if (!tx_empty) begin
            tx_pop = 1'b1; // [RULE_01]
            tv_d   = 1'b1;
            tb_d   = whiten_en ? txw_out : tx_head;
            tcnt_d = tcnt_q + 9'h001;
            if (tcnt_q == 9'h000) tlen_d = tx_head; // [RULE_10]
          end
        end
      end
      default: begin
        ts_d = T_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ts_q       <= T_IDLE;
      tcnt_q     <= 9'h000;
      tlen_q     <= 8'h00;
      tx_valid_q <= 1'b0;
      tx_byte_q  <= 8'h00;
    end else begin
      ts_q       <= ts_d;
      tcnt_q     <= tcnt_d;
      tlen_q     <= tlen_d;
      tx_valid_q <= tv_d;
      tx_byte_q  <= tb_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // fifos and whiteners
  rph_fifo #(.DEPTH(DEPTH)) u_rx_fifo (
    .pclk(pclk), .presetn(presetn), .wr_en(rx_push), .wr_data(rx_wd),
    .commit(rx_commit), .rollback(rx_drop), .rd_en(rx_pop),
    .rd_data(rx_head), .level(rx_lvl), .full(rx_full), .empty(rx_empty)
  );

  // tx writes commit at once; an overfull write is dropped silently
  rph_fifo #(.DEPTH(DEPTH)) u_tx_fifo (
    .pclk(pclk), .presetn(presetn), .wr_en(tx_wr), .wr_data(pwdata[7:0]),
    .commit(1'b1), .rollback(1'b0), .rd_en(tx_pop),
    .rd_data(tx_head), .level(tx_lvl), .full(), .empty(tx_empty)
  );

  rph_whiten u_rx_wh (
    .pclk(pclk), .presetn(presetn), .restart(rx_sync),
    .step(rx_push & in_body), .data_in(rx_byte), .data_out(rxw_out)
  );

  rph_whiten u_tx_wh (
    .pclk(pclk), .presetn(presetn), .restart(tx_sync),
    .step(tx_pop), .data_in(tx_head), .data_out(txw_out)
  );

  assign prdata   = prdata_q;
  assign pready   = pready_q;
  assign pslverr  = pslverr_q;
  assign irq      = irq_q;
  assign tx_valid = tx_valid_q;
  assign tx_byte  = tx_byte_q;

  //////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  fifo_bound_a: assert property ( // [RULE_01]
    rx_lvl <= (AW+1)'(DEPTH) && tx_lvl <= (AW+1)'(DEPTH))
    else $error("fifo level beyond depth");
  sync_insert_a: assert property ( // [RULE_02]
    ts_q == T_SYNC && tcnt_q[0] && ld
    |=> tx_valid_q && tx_byte_q == SYNC_WORD[7:0] && ts_q == T_DATA)
    else $error("second sync byte not sent");
  len_byte_a: assert property ( // [RULE_03]
    rs_q == R_LEN && rx_valid && !rx_end |-> rx_push || rx_drop)
    else $error("length byte not stored");
  append_pair_a: assert property ( // [RULE_04]
    rs_q == R_ST1 && append_q && !rx_full && fmt_normal
    |=> rs_q == R_ST2 ##1 rs_q == R_HUNT)
    else $error("status pair not appended");
  signal_strength_value_byte_a: assert property ( // [RULE_05]
    rs_q == R_ST1 && append_q |-> rx_wd == meta_q.signal_strength_value)
    else $error("first status byte wrong");
  crc_lqi_a: assert property ( // [RULE_06]
    rs_q == R_ST2 |-> rx_wd == {meta_q.crc_ok, meta_q.link_quality_value})
    else $error("second status byte wrong");
  eop_flag_a: assert property ( // [RULE_08]
    rx_eop || tx_eop |=> irq_st_q[IRQ_EOP])
    else $error("end event not flagged");
  fmt_gate_a: assert property ( // [RULE_09]
    !fmt_normal |=> rs_q == R_HUNT)
    else $error("rx active outside normal format");
  var_len_a: assert property ( // [RULE_10]
    rs_q == R_LEN && rx_valid && !rx_end && !rx_full && fmt_normal
    && rx_d != 8'h00 |=> rs_q == R_DATA && rlen_q == $past(rx_d))
    else $error("length byte not taken");
  fixed_drop_a: assert property ( // [RULE_11]
    rs_q == R_DATA && !var_mode && rx_end && rcnt_d != flen9
    |-> rx_drop)
    else $error("wrong length kept");
  fixed_ok_a: assert property ( // [RULE_14]
    rs_q == R_DATA && !var_mode && rx_end && rcnt_d == flen9
    && !rx_drop |=> rs_q == R_ST1)
    else $error("fixed packet not closed");
  drop_quiet_a: assert property ( // [RULE_15]
    rx_drop |-> !rx_eop && !rx_commit ##1 !irq_st_d[IRQ_EOP] || tx_eop
    || irq_st_q[IRQ_EOP])
    else $error("dropped packet signalled");

  rx_done_c: cover property (rs_q == R_ST2 ##1 rs_q == R_HUNT);
  rx_drop_c: cover property (rx_drop && rs_q == R_DATA);
  tx_done_c: cover property (tx_eop);

endmodule : rph_top

// >>> test/rph_radio_model.sv
// radio-side partner: receive byte source and stalling transmit sink
`timescale 1ns/1ps
module rph_radio_model
  import rph_pkg::*;
(
  input  wire logic       pclk,
  output logic            rx_valid,
  output logic [7:0]      rx_byte,
  output logic            rx_end,
  output rph_rx_meta_t    rx_meta,
  output logic            tx_ready,
  input  wire logic       tx_valid,
  input  wire logic [7:0] tx_byte
);
  logic [7:0] tx_got[$];
  logic [1:0] stall_q;

  initial begin
    rx_valid = 1'b0;
    rx_byte  = 8'hA5;
    rx_end   = 1'b0;
    rx_meta  = '0;
    tx_ready = 1'b0;
    stall_q  = 2'h0;
  end

  //////////////////////////////////////////////////////////////////////
  // receive side: released byte lane toggles so stale data never matches
  task automatic idle(input int n);
    repeat (n) begin
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_end   <= 1'b0;
      rx_byte  <= ~rx_byte;
    end
  endtask : idle

  task automatic set_meta(input logic [7:0] s, input logic ok,
                          input logic [6:0] q);
    rx_meta <= '{signal_strength_value: s, crc_ok: ok, link_quality_value: q};
  endtask : set_meta

  // bytes back to back, optional end strobe, then idle gap
  task automatic frame(input logic [7:0] q[$], input logic fin,
                       input int gap);
    foreach (q[i]) begin
      @(posedge pclk);
      rx_valid <= 1'b1;
      rx_byte  <= q[i];
    end
    if (fin) begin
      @(posedge pclk);
      rx_valid <= 1'b0;
      rx_end   <= 1'b1;
      rx_byte  <= ~rx_byte;
    end
    idle(gap);
  endtask : frame

  //////////////////////////////////////////////////////////////////////
  // transmit side: ready drops one cycle in four to exercise holding
  always @(posedge pclk) begin
    stall_q  <= stall_q + 2'h1;
    tx_ready <= (stall_q != 2'h2);
    if (tx_valid && tx_ready) begin
      tx_got.push_back(tx_byte);
    end
  end
endmodule : rph_radio_model

// >>> test/test_radio_packet_handler.sv
// self-checking bench: apb tasks and packet scenarios
`timescale 1ns/1ps
module test_radio_packet_handler;
  import rph_pkg::*;
  localparam int CEIL = 6000;
  logic         pclk;
  logic         presetn;
  logic         psel;
  logic         penable;
  logic         pwrite;
  logic [7:0]   paddr;
  logic [31:0]  pwdata;
  wire  [31:0]  prdata;
  wire          pready;
  wire          pslverr;
  wire          irq;
  wire          rx_valid;
  wire  [7:0]   rx_byte;
  wire          rx_end;
  rph_rx_meta_t rx_meta;
  wire          tx_ready;
  wire          tx_valid;
  wire  [7:0]   tx_byte;
  int           mismatches;
  int           checks;
  int           cycles;
  logic [31:0]  rd;
  logic         err;
  logic [7:0]   exp_tx[$];

`define CHK(nm, exp, got) \
  begin \
    checks++; \
    if ((got) !== (exp)) begin \
      mismatches++; \
      $display("ERROR %s expected %0h seen %0h", nm, exp, got); \
    end \
  end

  rph_top #(.DEPTH(FIFO_DEPTH)) DUT (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_end(rx_end), .rx_meta(rx_meta),
    .tx_ready(tx_ready), .tx_valid(tx_valid), .tx_byte(tx_byte));

  rph_radio_model u_radio (
    .pclk(pclk), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end),
    .rx_meta(rx_meta), .tx_ready(tx_ready), .tx_valid(tx_valid),
    .tx_byte(tx_byte));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  //////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge pclk) begin
    cycles++;
    if (cycles == CEIL) begin
      mismatches++;
      report_and_stop();
    end
  end

  // one apb transfer; waits for pready with no assumed latency
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input string nm, input logic [7:0] a,
                        input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(nm, e, rd)
    `CHK("pslverr", 1'b0, err)
  endtask : rd_chk

  task automatic fifo_chk(input logic [7:0] q[$]);
    foreach (q[i]) begin
      rd_chk("rx fifo", OFF_FIFO, {24'h0, q[i]});
    end
  endtask : fifo_chk

  // ends once the end event bit reads set; only the bench timeout bounds this wait
  task automatic poll_eop();
    do begin
      apb(1'b0, OFF_IRQ_ST, 32'h0);
    end while (rd[1] !== 1'b1);
  endtask : poll_eop

  //////////////////////////////////////////////////////////////////////
  initial begin
    presetn = 1'b0;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk("ctrl", OFF_CTRL, {24'h0, CTRL_RST});
    rd_chk("flen", OFF_FLEN, {24'h0, FLEN_RST});
    rd_chk("aux", OFF_AUX, 32'h00000001);
    rd_chk("mask", OFF_IRQ_MSK, 32'h0);
    rd_chk("level", OFF_LEVEL, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    `CHK("unmapped err", 1'b1, err)
    `CHK("unmapped data", 32'h0, rd)
    // variable length receive with status bytes; small frames only
    apb(1'b1, OFF_IRQ_MSK, 32'h3);
    u_radio.set_meta(8'hA7, 1'b1, 7'h2B);
    u_radio.frame('{8'h3C, 8'h5A, 8'h02, 8'hC1, 8'hC2}, 1'b0, 6);
    rd_chk("status", OFF_IRQ_ST, 32'h3);
    `CHK("irq set", 1'b1, irq)
    rd_chk("level", OFF_LEVEL, 32'h00050000);
    fifo_chk('{8'h02, 8'hC1, 8'hC2, 8'hA7, 8'hAB});
    rd_chk("level", OFF_LEVEL, 32'h0);
    apb(1'b1, OFF_IRQ_ST, 32'h3);
    rd_chk("status", OFF_IRQ_ST, 32'h0);
    `CHK("irq clr", 1'b0, irq)
    // fixed length: matching packet kept, short one dropped
    apb(1'b1, OFF_CTRL, 32'h0);
    apb(1'b1, OFF_FLEN, 32'h3);
    u_radio.set_meta(8'h9C, 1'b0, 7'h11);
    u_radio.frame('{8'h3C, 8'h5A, 8'hD1, 8'hD2, 8'hD3}, 1'b1, 6);
    rd_chk("status", OFF_IRQ_ST, 32'h3);
    fifo_chk('{8'hD1, 8'hD2, 8'hD3, 8'h9C, 8'h11});
    apb(1'b1, OFF_IRQ_ST, 32'h7);
    apb(1'b1, OFF_IRQ_MSK, 32'h2);
    u_radio.frame('{8'h3C, 8'h5A, 8'hE1, 8'hE2}, 1'b1, 6);
    rd_chk("status", OFF_IRQ_ST, 32'h5);
    `CHK("irq masked", 1'b0, irq)
    rd_chk("level", OFF_LEVEL, 32'h0);
    apb(1'b1, OFF_IRQ_ST, 32'h7);
    // append disabled: only length and data land
    apb(1'b1, OFF_CTRL, 32'h1);
    apb(1'b1, OFF_AUX, 32'h0);
    u_radio.frame('{8'h3C, 8'h5A, 8'h01, 8'hF1}, 1'b0, 6);
    rd_chk("level", OFF_LEVEL, 32'h00020000);
    fifo_chk('{8'h01, 8'hF1});
    apb(1'b1, OFF_IRQ_ST, 32'h7);
    // transmit: preamble, sync, then fifo payload
    exp_tx = '{8'h55, 8'h55, 8'h55, 8'h55, 8'h3C, 8'h5A, 8'h02, 8'hAA, 8'hBB};
    apb(1'b1, OFF_FIFO, 32'h02);
    apb(1'b1, OFF_FIFO, 32'hAA);
    apb(1'b1, OFF_FIFO, 32'hBB);
    apb(1'b1, OFF_AUX, 32'h3);
    poll_eop();
    `CHK("tx status", 32'h3, rd)
    `CHK("tx count", 9, u_radio.tx_got.size())
    foreach (exp_tx[i]) begin
      `CHK("tx byte", exp_tx[i], u_radio.tx_got[i])
    end
    apb(1'b1, OFF_IRQ_ST, 32'h7);
    // other packet format idles both engines
    apb(1'b1, OFF_CTRL, 32'h11);
    apb(1'b1, OFF_FIFO, 32'h01);
    apb(1'b1, OFF_FIFO, 32'h77);
    apb(1'b1, OFF_AUX, 32'h3);
    u_radio.frame('{8'h3C, 8'h5A, 8'h01, 8'h99}, 1'b0, 6);
    rd_chk("status", OFF_IRQ_ST, 32'h0);
    rd_chk("level", OFF_LEVEL, 32'h00000200);
    `CHK("tx idle", 9, u_radio.tx_got.size())
    // transmit fifo holds exactly 64 bytes
    for (int i = 0; i < 70; i++) begin
      apb(1'b1, OFF_FIFO, i);
    end
    rd_chk("level", OFF_LEVEL, 32'h00004000);
    // whitening on: pn9 bytes ff then e1 scramble length and data
    apb(1'b1, OFF_CTRL, 32'h41);
    apb(1'b1, OFF_AUX, 32'h3);
    poll_eop();
    `CHK("wh count", 17, u_radio.tx_got.size())
    `CHK("wh len", 8'hFE, u_radio.tx_got[15])
    `CHK("wh data", 8'h96, u_radio.tx_got[16])
    u_radio.frame('{8'h3C, 8'h5A, 8'hFE, 8'h96}, 1'b0, 6);
    fifo_chk('{8'h01, 8'h77, 8'h9C, 8'h11});
    report_and_stop();
  end
endmodule : test_radio_packet_handler
